// [core/psrs_top.sv]
`timescale 1ns/1ps
`include "psrs_map.svh"

// Function
// (R01) Power button falling edge leaves soft-off
// (R02) Reset button falling edge starts reset
// (R03) Held reset button does not extend reset
// (R04) Carrier reset on button, supply, voltage, watchdog, software
// (R05) Carrier keeps supply-good high only when good
// (R06) Warn attached devices before entering low power
// (R07) Option: shared pin becomes side bus reset
// (R08) Suspend-to-RAM indication low in that state
// (R09) Suspend-to-disk indication low in disk or off
// (R10) Soft-off indication asserted only in soft-off
// (R11) Watchdog expiry output after time-out event
// (R12) PCI Express wake low requests wake-up
// (R13) Auxiliary wake low requests wake-up
// (R14) Battery-low low reports low battery
// (R15) Lid switch state passed to software
// (R16) Sleep button reported to software
// (R17) Over-temperature low reports hot condition
// (R18) Thermal shutdown output low on CPU trip
// (R19) Two-flop synchronise every asynchronous input
module psrs_top
  import psrs_pkg::*;
#(
  parameter int RST_CYC = `PSRS_RST_CYC,
  parameter int WARN_CYC = `PSRS_WARN_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Carrier pins, asynchronous
  input wire logic i_power_button_n,
  input wire logic i_reset_button_n,
  input wire logic i_supply_good,
  input wire logic i_main_input_voltage_low,
  input wire logic i_pcie_wake_n,
  input wire logic i_aux_wake_n,
  input wire logic i_battery_low_n,
  input wire logic i_lid_n,
  input wire logic i_sleep_button_n,
  input wire logic i_overtemp_in_n,
  // Chipset side, same clock
  input wire logic i_watchdog_timeout,
  input wire logic i_watchdog_clear,
  input wire logic i_sw_reset,
  input wire logic i_sleep_req,
  input wire psrs_target_t i_sleep_target,
  input wire logic i_cpu_thermal_trip,
  input wire logic i_side_bus_option,
  // Carrier outputs
  output logic o_carrier_reset_n,
  output logic o_low_power_warning_n,
  output logic o_suspend_ram_n,
  output logic o_suspend_disk_n,
  output logic o_soft_off_n,
  output logic o_watchdog_expired,
  output logic o_thermal_shutdown_n,
  // Software status
  output psrs_pm_t o_pm_status,
  output psrs_state_t o_power_state
);

  // ==========================================================
  // Input synchronisation
  psrs_pins_t pins_raw;
  psrs_pins_t pins_s;
  psrs_pins_t prev_reg;
  psrs_pins_t prev_next;
  logic pb_fall;
  logic rb_fall;
  logic sl_fall;
  logic wake_req;

  // Pins gathered in struct order
  always_comb begin
    pins_raw = '{power_button_n: i_power_button_n, reset_button_n: i_reset_button_n,
                 supply_good: i_supply_good, main_input_low: i_main_input_voltage_low,
                 pcie_wake_n: i_pcie_wake_n, aux_wake_n: i_aux_wake_n,
                 battery_low_n: i_battery_low_n, lid_n: i_lid_n,
                 sleep_button_n: i_sleep_button_n, overtemp_in_n: i_overtemp_in_n};
  end

  // No edge detector looks at a first stage
  psrs_sync #(
    .W(`PSRS_PIN_W),
    .RST_VAL(`PSRS_PINS_IDLE)
  ) u_sync ( // [R19]
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_async(pins_raw),
    .o_sync(pins_s)
  );

  // Edge detection on synchronised levels only
  always_comb begin
    prev_next = pins_s;
    pb_fall = prev_reg.power_button_n & ~pins_s.power_button_n; // [R01]
    rb_fall = prev_reg.reset_button_n & ~pins_s.reset_button_n; // [R02]
    sl_fall = prev_reg.sleep_button_n & ~pins_s.sleep_button_n;
    wake_req = pb_fall | sl_fall | ~pins_s.pcie_wake_n | ~pins_s.aux_wake_n; // [R12] [R13]
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      prev_reg <= `PSRS_PINS_IDLE;
    end else begin
      prev_reg <= prev_next;
    end
  end

  // ==========================================================
  // Power state machine
  psrs_state_t state_reg;
  psrs_state_t state_next;
  psrs_target_t tgt_reg;
  psrs_target_t tgt_next;
  logic [`PSRS_CNT_W-1:0] warn_reg;
  logic [`PSRS_CNT_W-1:0] warn_next;
  logic therm_reg;
  logic therm_next;

  // A CPU trip overrides every other transition and latches until power-up
  always_comb begin
    state_next = state_reg;
    tgt_next = tgt_reg;
    warn_next = warn_reg;
    therm_next = therm_reg | i_cpu_thermal_trip; // [R18]
    unique case (state_reg)
      PSRS_ON: begin
        if (i_sleep_req) begin
          state_next = PSRS_WARN; // [R06]
          tgt_next = i_sleep_target;
          warn_next = `PSRS_CNT_W'(WARN_CYC - 1);
        end
      end
      PSRS_WARN: begin
        if (warn_reg == `PSRS_CNT_ZERO) begin
          unique case (tgt_reg)
            PSRS_TGT_RAM: state_next = PSRS_STR;
            PSRS_TGT_DISK: state_next = PSRS_STD;
            default: state_next = PSRS_OFF;
          endcase
        end else begin
          warn_next = warn_reg - `PSRS_CNT_ONE;
        end
      end
      PSRS_STR, PSRS_STD: begin
        if (wake_req) begin
          state_next = PSRS_ON; // [R12] [R13]
        end
      end
      PSRS_OFF: begin
        if (pb_fall) begin
          state_next = PSRS_ON; // [R01]
          therm_next = i_cpu_thermal_trip;
        end
      end
    endcase
    if (i_cpu_thermal_trip) begin
      state_next = PSRS_OFF;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= PSRS_OFF;
      tgt_reg <= PSRS_TGT_OFF;
      warn_reg <= `PSRS_CNT_ZERO;
      therm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tgt_reg <= tgt_next;
      warn_reg <= warn_next;
      therm_reg <= therm_next;
    end
  end

  // ==========================================================
  // Reset pulse and watchdog
  logic [`PSRS_CNT_W-1:0] rst_cnt_reg;
  logic [`PSRS_CNT_W-1:0] rst_cnt_next;
  logic wdog_reg;
  logic wdog_next;
  logic side_reg;
  logic side_next;
  logic strap_done_reg;
  logic strap_done_next;

  // Pulse length is fixed, so a button held low cannot stretch it
  always_comb begin
    rst_cnt_next = rst_cnt_reg;
    if (rb_fall || i_watchdog_timeout) begin
      rst_cnt_next = `PSRS_CNT_W'(RST_CYC - 1); // [R02] [R04]
    end else if (rst_cnt_reg != `PSRS_CNT_ZERO) begin
      rst_cnt_next = rst_cnt_reg - `PSRS_CNT_ONE; // [R03]
    end
    // A time-out in the clearing cycle still sets the flag
    wdog_next = i_watchdog_timeout | (wdog_reg & ~i_watchdog_clear); // [R11]
    // Assembly option caught once, just after reset release
    strap_done_next = 1'b1;
    side_next = strap_done_reg ? side_reg : i_side_bus_option; // [R07]
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rst_cnt_reg <= `PSRS_CNT_ZERO;
      wdog_reg <= 1'b0;
      side_reg <= 1'b0;
      strap_done_reg <= 1'b0;
    end else begin
      rst_cnt_reg <= rst_cnt_next;
      wdog_reg <= wdog_next;
      side_reg <= side_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // ==========================================================
  // Output registers, computed from next state so they track it exactly
  logic crst_n_next;
  logic lpw_n_next;
  psrs_pm_t pm_next;
  logic asleep_next;

  always_comb begin
    asleep_next = state_next != PSRS_ON;
    // A bad supply is taken as power not good, never filtered
    crst_n_next = ~((rst_cnt_next != `PSRS_CNT_ZERO) | ~pins_s.supply_good | pins_s.main_input_low
                  | i_sw_reset | asleep_next); // [R04] [R05]
    // The shared pin warns in low power, or resets the side bus
    lpw_n_next = side_next ? crst_n_next : ~asleep_next; // [R06] [R07]
    pm_next.lid_closed = ~pins_s.lid_n; // [R15]
    pm_next.sleep_pressed = ~pins_s.sleep_button_n; // [R16]
    pm_next.battery_low = ~pins_s.battery_low_n; // [R14]
    pm_next.overtemp = ~pins_s.overtemp_in_n; // [R17]
    pm_next.wake_pending = ~pins_s.pcie_wake_n | ~pins_s.aux_wake_n;
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_carrier_reset_n <= 1'b0;
      o_low_power_warning_n <= 1'b0;
      o_suspend_ram_n <= 1'b1;
      o_suspend_disk_n <= 1'b0;
      o_soft_off_n <= 1'b0;
      o_watchdog_expired <= 1'b0;
      o_thermal_shutdown_n <= 1'b1;
      o_pm_status <= '0;
      o_power_state <= PSRS_OFF;
    end else begin
      o_carrier_reset_n <= crst_n_next;
      o_low_power_warning_n <= lpw_n_next;
      o_suspend_ram_n <= state_next != PSRS_STR; // [R08]
      o_suspend_disk_n <= (state_next != PSRS_STD) && (state_next != PSRS_OFF); // [R09]
      o_soft_off_n <= state_next != PSRS_OFF; // [R10]
      o_watchdog_expired <= wdog_next; // [R11]
      o_thermal_shutdown_n <= ~therm_next; // [R18]
      o_pm_status <= pm_next;
      o_power_state <= state_next;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  pwr_up_a: assert property ( // [R01]
    state_reg == PSRS_OFF && pb_fall && !i_cpu_thermal_trip |=> o_power_state == PSRS_ON && o_soft_off_n)
    else $error("power button edge did not leave soft-off");
  rst_edge_a: assert property ( // [R02]
    rb_fall |=> !o_carrier_reset_n && rst_cnt_reg == `PSRS_CNT_W'(RST_CYC - 1))
    else $error("reset button edge did not start reset");
  rst_end_a: assert property ( // [R03]
    rst_cnt_reg == `PSRS_CNT_ONE && !rb_fall && !i_watchdog_timeout |=> rst_cnt_reg == `PSRS_CNT_ZERO)
    else $error("reset pulse stretched");
  crst_cause_a: assert property ( // [R04]
    !pins_s.supply_good || pins_s.main_input_low || i_sw_reset || i_watchdog_timeout |=> !o_carrier_reset_n)
    else $error("carrier reset not driven");
  warn_lead_a: assert property ( // [R06]
    state_reg == PSRS_ON && i_sleep_req && !i_cpu_thermal_trip && !side_reg
    |=> o_power_state == PSRS_WARN && !o_low_power_warning_n)
    else $error("no low-power warning before sleep");
  side_mode_a: assert property ( // [R07]
    side_reg |-> o_low_power_warning_n == o_carrier_reset_n)
    else $error("shared pin does not follow side bus reset");
  str_ind_a: assert property ( // [R08]
    o_suspend_ram_n == (state_reg != PSRS_STR))
    else $error("suspend-to-RAM indication wrong");
  std_ind_a: assert property ( // [R09]
    !o_suspend_disk_n == (state_reg inside {PSRS_STD, PSRS_OFF}))
    else $error("suspend-to-disk indication wrong");
  off_ind_a: assert property ( // [R10]
    !o_soft_off_n == (state_reg == PSRS_OFF))
    else $error("soft-off indication wrong");
  wdog_set_a: assert property ( // [R11]
    i_watchdog_timeout |=> o_watchdog_expired ##1 (o_watchdog_expired || $past(i_watchdog_clear)))
    else $error("watchdog expiry not shown");
  wake_req_a: assert property ( // [R12]
    state_reg inside {PSRS_STR, PSRS_STD} && (!pins_s.pcie_wake_n || !pins_s.aux_wake_n)
    && !i_cpu_thermal_trip |=> o_power_state == PSRS_ON)
    else $error("wake request ignored");
  ot_rep_a: assert property ( // [R17]
    o_pm_status.overtemp == !$past(pins_s.overtemp_in_n) && o_pm_status.battery_low == !$past(pins_s.battery_low_n))
    else $error("status bits do not track pins");
  trip_out_a: assert property ( // [R18]
    i_cpu_thermal_trip |=> !o_thermal_shutdown_n && o_power_state == PSRS_OFF)
    else $error("thermal shutdown not driven");

  up_c: cover property (state_reg == PSRS_OFF ##1 state_reg == PSRS_ON);
  str_c: cover property (state_reg == PSRS_WARN ##1 state_reg == PSRS_STR);
  wake_c: cover property (state_reg == PSRS_STR ##1 state_reg == PSRS_ON);
  wdog_c: cover property (i_watchdog_timeout ##1 !o_carrier_reset_n);

endmodule : psrs_top

// [inc/psrs_map.svh]
`ifndef PSRS_MAP_SVH
`define PSRS_MAP_SVH

// ==========================================================
// Timing figures
`define PSRS_CLK_MHZ 40
// Low-power warning lead time before a sleep state, in ns
`define PSRS_WARN_NS 1000
// Rounded up to whole cycles
`define PSRS_WARN_CYC ((`PSRS_WARN_NS * `PSRS_CLK_MHZ + 999) / 1000)
// Carrier reset pulse length after a button edge or watchdog, in us
`define PSRS_RST_US 100
`define PSRS_RST_CYC (`PSRS_RST_US * `PSRS_CLK_MHZ)

// ==========================================================
// Widths and reset values
`define PSRS_CNT_W 12
`define PSRS_CNT_ZERO 12'h000
`define PSRS_CNT_ONE 12'h001
`define PSRS_PIN_W 10
// Idle level of each synchronised pin: buttons released, supply bad
`define PSRS_PINS_IDLE 10'h33f

`endif

// [inc/psrs_pkg.sv]
package psrs_pkg;

  // ==========================================================
  // Power states
  typedef enum logic [2:0] {
    PSRS_ON,
    PSRS_WARN,
    PSRS_STR,
    PSRS_STD,
    PSRS_OFF
  } psrs_state_t;

  // Sleep target that software asks for
  typedef enum logic [1:0] {
    PSRS_TGT_RAM,
    PSRS_TGT_DISK,
    PSRS_TGT_OFF
  } psrs_target_t;

  // ==========================================================
  // Carrier pins, in synchroniser order
  typedef struct packed {
    logic power_button_n;
    logic reset_button_n;
    logic supply_good;
    logic main_input_low;
    logic pcie_wake_n;
    logic aux_wake_n;
    logic battery_low_n;
    logic lid_n;
    logic sleep_button_n;
    logic overtemp_in_n;
  } psrs_pins_t;

  // Status shown to power-management software, active high
  typedef struct packed {
    logic lid_closed;
    logic sleep_pressed;
    logic battery_low;
    logic overtemp;
    logic wake_pending;
  } psrs_pm_t;

endpackage : psrs_pkg

// [core/psrs_sync.sv]
`timescale 1ns/1ps
`include "psrs_map.svh"

// ==========================================================
// Two-stage synchroniser for a group of asynchronous levels
module psrs_sync #(
  parameter int W = `PSRS_PIN_W,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Levels
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // First stage feeds only the second stage
  always_comb begin
    meta_next = i_async;
    sync_next = meta_reg;
  end

  // Both stages load the idle levels under reset
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign o_sync = sync_reg;

endmodule : psrs_sync

// [tb/psrs_carrier.sv]
`timescale 1ns/1ps

// ==========================================================
// Carrier board: pulled-up buttons and wake lines, main supply
module psrs_carrier
  import psrs_pkg::*;
(
  // Clock
  input wire logic i_clock,
  // Pins toward the module
  output psrs_pins_t o_pins
);
  psrs_pins_t pins_reg;

  // Released lines rest at their pull-up, supply good, input voltage fine
  initial begin
    pins_reg = '1;
    pins_reg.main_input_low = 1'b0;
  end
  assign o_pins = pins_reg;

  // Lines only move off the sampling edge
  task set_line(input int sel, input logic lvl);
    @(negedge i_clock);
    pins_reg[sel] = lvl;
  endtask : set_line

  // Supply good stays high only while the rail is good
  task rail(input logic ok);
    @(negedge i_clock);
    pins_reg.supply_good = ok;
  endtask : rail

  // A press always returns to the pull-up level, never leaves it floating
  task press(input int sel, input int hold);
    set_line(sel, 1'b0);
    repeat (hold) @(negedge i_clock);
    pins_reg[sel] = 1'b1;
  endtask : press
endmodule : psrs_carrier

// [tb/psrs_bench.sv]
`timescale 1ns/1ps

module psrs_bench;
  import psrs_pkg::*;
  // Short counts keep the run brief; the reset and warning waits derive from these
  localparam int RST_N = 8;
  localparam int WARN_N = 2;
  localparam int PB = 9;
  localparam int RB = 8;
  localparam int VL = 6;
  localparam int PW = 5;
  localparam int AW = 4;
  localparam int SB = 1;
  logic clock, sys_rst, wd_to, wd_clr, sw_rst, slp_req, trip, opt;
  psrs_target_t tgt;
  psrs_pins_t pins;
  logic car_n, warn_n, ram_n, disk_n, off_n, wd_exp, therm_n;
  psrs_pm_t pm;
  psrs_state_t st;
  int error_cnt, check_count;

  // ==========================================================
  // Clock, carrier and design
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  psrs_carrier u_car (.i_clock(clock), .o_pins(pins));

  psrs_top #(.RST_CYC(RST_N), .WARN_CYC(WARN_N)) u_dut (
    .i_clock(clock), .i_sys_rst(sys_rst),
    .i_power_button_n(pins.power_button_n), .i_reset_button_n(pins.reset_button_n),
    .i_supply_good(pins.supply_good), .i_main_input_voltage_low(pins.main_input_low),
    .i_pcie_wake_n(pins.pcie_wake_n), .i_aux_wake_n(pins.aux_wake_n),
    .i_battery_low_n(pins.battery_low_n), .i_lid_n(pins.lid_n),
    .i_sleep_button_n(pins.sleep_button_n), .i_overtemp_in_n(pins.overtemp_in_n),
    .i_watchdog_timeout(wd_to), .i_watchdog_clear(wd_clr), .i_sw_reset(sw_rst),
    .i_sleep_req(slp_req), .i_sleep_target(tgt), .i_cpu_thermal_trip(trip),
    .i_side_bus_option(opt),
    .o_carrier_reset_n(car_n), .o_low_power_warning_n(warn_n), .o_suspend_ram_n(ram_n),
    .o_suspend_disk_n(disk_n), .o_soft_off_n(off_n), .o_watchdog_expired(wd_exp),
    .o_thermal_shutdown_n(therm_n), .o_pm_status(pm), .o_power_state(st)
  );

  // ==========================================================
  // Shared helpers
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Strap must already be valid on the edge that follows release
  task do_reset(input logic strap);
    opt = strap;
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
  endtask : do_reset

  task power_up();
    u_car.press(PB, 4);
    cyc(1);
    chk("state", PSRS_ON, st);
    chk("soft_off_n", 1'b1, off_n);
    chk("disk_n", 1'b1, disk_n);
    chk("carrier_n", 1'b1, car_n);
  endtask : power_up

  // ==========================================================
  // Scenarios
  task t_start();
    chk("state", PSRS_OFF, st);
    chk("soft_off_n", 1'b0, off_n);
    chk("disk_n", 1'b0, disk_n);
    chk("ram_n", 1'b1, ram_n);
    chk("therm_n", 1'b1, therm_n);
    power_up();
    $display("start test done");
  endtask : t_start

  // Reset pulse has a fixed length even with the button still held
  task t_reset_btn();
    u_car.set_line(RB, 1'b0);
    cyc(4);
    chk("carrier_n", 1'b0, car_n);
    cyc(RST_N + 6);
    chk("carrier_n", 1'b1, car_n);
    u_car.set_line(RB, 1'b1);
    cyc(4);
    chk("carrier_n", 1'b1, car_n);
    $display("reset button test done");
  endtask : t_reset_btn

  task t_sources();
    u_car.rail(1'b0);
    cyc(4);
    chk("carrier_n", 1'b0, car_n);
    u_car.rail(1'b1);
    cyc(4);
    chk("carrier_n", 1'b1, car_n);
    u_car.set_line(VL, 1'b1);
    cyc(4);
    chk("carrier_n", 1'b0, car_n);
    u_car.set_line(VL, 1'b0);
    sw_rst = 1'b1;
    cyc(4);
    chk("carrier_n", 1'b0, car_n);
    chk("warn_n", 1'b1, warn_n);
    sw_rst = 1'b0;
    cyc(2);
    chk("carrier_n", 1'b1, car_n);
    $display("reset sources test done");
  endtask : t_sources

  task t_watchdog();
    wd_to = 1'b1;
    cyc(1);
    wd_to = 1'b0;
    chk("wd_expired", 1'b1, wd_exp);
    chk("carrier_n", 1'b0, car_n);
    cyc(RST_N + 2);
    chk("carrier_n", 1'b1, car_n);
    chk("wd_expired", 1'b1, wd_exp);
    wd_clr = 1'b1;
    cyc(1);
    wd_clr = 1'b0;
    cyc(1);
    chk("wd_expired", 1'b0, wd_exp);
    $display("watchdog test done");
  endtask : t_watchdog

  // Warning phase, target state, a refused wake where one applies, wake
  task t_sleep(input psrs_target_t t, input psrs_state_t exp, input int wake);
    slp_req = 1'b1;
    tgt = t;
    cyc(1);
    slp_req = 1'b0;
    chk("state", PSRS_WARN, st);
    chk("warn_n", 1'b0, warn_n);
    cyc(WARN_N + 1);
    chk("state", exp, st);
    chk("ram_n", exp != PSRS_STR, ram_n);
    chk("disk_n", exp == PSRS_ON || exp == PSRS_STR, disk_n);
    chk("soft_off_n", exp != PSRS_OFF, off_n);
    if (exp == PSRS_OFF) begin
      u_car.press(AW, 4);
      cyc(2);
      chk("state", PSRS_OFF, st);
    end
    u_car.press(wake, 4);
    cyc(2);
    chk("state", PSRS_ON, st);
    // Wake lines are still seen low here; buttons never raise the pending bit
    chk("wake_pending", wake == PW || wake == AW, pm.wake_pending);
    $display("sleep test done");
  endtask : t_sleep

  task t_status();
    static logic [4:0] exp [4] = '{5'h04, 5'h10, 5'h08, 5'h02};
    for (int i = 0; i < 4; i++) begin
      u_car.set_line(3 - i, 1'b0);
      cyc(4);
      chk("pm_status", exp[i], pm);
      u_car.set_line(3 - i, 1'b1);
      cyc(4);
    end
    chk("state", PSRS_ON, st);
    $display("status test done");
  endtask : t_status

  task t_thermal();
    trip = 1'b1;
    cyc(1);
    trip = 1'b0;
    chk("state", PSRS_OFF, st);
    chk("therm_n", 1'b0, therm_n);
    cyc(5);
    chk("therm_n", 1'b0, therm_n);
    power_up();
    chk("therm_n", 1'b1, therm_n);
    $display("thermal test done");
  endtask : t_thermal

  // With the option strapped the warning pin mirrors the carrier reset
  task t_side_bus();
    do_reset(1'b1);
    cyc(3);
    power_up();
    sw_rst = 1'b1;
    cyc(3);
    chk("side_reset_n", 1'b0, warn_n);
    sw_rst = 1'b0;
    cyc(3);
    chk("side_reset_n", 1'b1, warn_n);
    $display("side bus test done");
  endtask : t_side_bus

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    {wd_to, wd_clr, sw_rst, slp_req, trip} = '0;
    tgt = PSRS_TGT_RAM;
    error_cnt = 0;
    check_count = 0;
    do_reset(1'b0);
    t_start();
    t_reset_btn();
    t_sources();
    t_watchdog();
    t_sleep(PSRS_TGT_RAM, PSRS_STR, PW);
    t_sleep(PSRS_TGT_DISK, PSRS_STD, AW);
    t_sleep(PSRS_TGT_OFF, PSRS_OFF, PB);
    t_sleep(PSRS_TGT_RAM, PSRS_STR, SB);
    t_status();
    t_thermal();
    t_side_bus();
    wrap_up();
  end

  // The whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clock);
    error_cnt++;
    $display("[ERR] run expected done seen hang");
    wrap_up();
  end
endmodule : psrs_bench
